//--- pkg/lcr_pkg.sv
// Purpose: shared constants and types for the link control and interrupt register bank
// Assumes: 8-bit register addresses and data from the slave control port front end
// Notes:   one clock domain; the sync step count derives from the 125 MHz clock, the mute hold counts packets
package lcr_pkg;

    // register addresses
    localparam logic [7:0] ADDR_IRQ_FLAGS     = 8'h02;
    localparam logic [7:0] ADDR_LINK_STATE    = 8'h03;
    localparam logic [7:0] ADDR_MUTE_HOLD     = 8'h0B;
    localparam logic [7:0] ADDR_LINK_MODE     = 8'h36;
    localparam logic [7:0] ADDR_REMOTE_UPDATE = 8'h3E;
    localparam logic [7:0] ADDR_RX_POWER      = 8'h49;
    localparam logic [7:0] ADDR_LATENCY       = 8'h52;
    localparam logic [7:0] ADDR_IRQ_CONFIG    = 8'h53;
    localparam logic [7:0] ADDR_TX_POWER      = 8'h56;
    localparam logic [7:0] ADDR_SYNC_DELAY    = 8'h57;

    // field positions
    localparam int LINK_UP_BIT      = 0;
    localparam int MODE_MUTE_EN_BIT = 0;
    localparam int MODE_NO_HOP_BIT  = 2;
    localparam int MODE_RECONF_BIT  = 4;
    localparam int MODE_RESTORE_BIT = 6;
    localparam int IRQ_DATA_BIT     = 3;
    localparam int IRQ_REMOTE_BIT   = 4;
    localparam int IRQ_BROKEN_BIT   = 6;
    localparam int IRQ_POL_BIT      = 7;

    // writable masks; everything else reads as zero
    localparam logic [7:0] LINK_MODE_MASK = 8'h45;
    localparam logic [7:0] IRQ_FLAG_MASK  = 8'h58;
    localparam logic [7:0] IRQ_CFG_MASK   = 8'hD8;
    localparam logic [7:0] POWER_MASK     = 8'h03;

    // reset values
    localparam logic [7:0] SYNC_DELAY_RST = 8'h77;
    localparam logic [7:0] LATENCY_RST    = 8'h06;
    localparam logic [7:0] POWER_RST      = 8'h03;
    localparam logic [7:0] MUTE_HOLD_RST  = 8'h00;
    localparam logic [7:0] ZERO_RST       = 8'h00;

    // latency and remote update encodings
    localparam logic [7:0] LATENCY_MEDIUM = 8'h04;
    localparam logic [7:0] LATENCY_HIGH   = 8'h06;
    localparam logic [7:0] REMOTE_IDLE_OK = 8'h00;
    localparam logic [7:0] REMOTE_BUSY    = 8'h01;
    localparam logic [7:0] REMOTE_FAILED  = 8'h02;

    // timing
    localparam int CLK_HZ          = 125_000_000;
    localparam int SYNC_STEP_NS    = 16_000;
    localparam int SYNC_STEP_CYC   = (SYNC_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int MUTE_PKT_FACTOR = 24;

    // register access request from the slave control port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lcr_req_t;

    // events and status from the radio core
    typedef struct packed {
        logic link_up;
        logic init_fail;
        logic remote_done;
        logic remote_fail;
        logic data_rx;
        logic pkt_valid;
        logic pkt_err;
        logic audio_lost;
    } lcr_core_t;

endpackage

//--- rtl/lcr_mute_hold.sv
// Purpose: minimum mute interval counter for the audio receiver
// Assumes: packet strobes are one-cycle pulses on clk_i
// Notes:   with the feature off, the first clean packet un-mutes
`timescale 1ns/1ps
module lcr_mute_hold
    import lcr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // control
    input  wire logic       enable_i,
    input  wire logic [7:0] hold_count_i,
    // packet events
    input  wire logic       audio_lost_i,
    input  wire logic       pkt_valid_i,
    input  wire logic       pkt_err_i,
    // status
    output logic            mute_o
);
    logic [12:0] good_cnt_ff;
    logic [12:0] target;

    // hold count times 24 packets; 13 bits cover 255 x 24
    assign target = 13'(hold_count_i) * 13'(MUTE_PKT_FACTOR);

    // mute state and run of clean packets
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mute_o      <= 1'b1;
            good_cnt_ff <= 13'h0000;
        end
        else if (audio_lost_i || (pkt_valid_i && pkt_err_i))
        begin
            mute_o      <= 1'b1;
            good_cnt_ff <= 13'h0000;
        end
        else if (mute_o && pkt_valid_i)
        begin
            if (!enable_i || (good_cnt_ff + 13'h0001 >= target))
            begin
                mute_o      <= 1'b0;
                good_cnt_ff <= 13'h0000;
            end
            else
            begin
                good_cnt_ff <= good_cnt_ff + 13'h0001;
            end
        end
    end
endmodule

//--- rtl/lcr_sync_delay.sv
// Purpose: sync pulse generation and alignment between two paired receivers
// Assumes: frame_ref_i pulses 119 steps ahead of the nominal sync instant
// Notes:   delay value is captured when sync is enabled, not tracked live
`timescale 1ns/1ps
module lcr_sync_delay
    import lcr_pkg::*;
#(
    parameter int STEP_CYC = SYNC_STEP_CYC
)
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // control
    input  wire logic       sync_en_i,
    input  wire logic [7:0] delay_i,
    input  wire logic       frame_ref_i,
    // pins
    input  wire logic       sync_role_select_pin_i,
    input  wire logic       sync_pin_i,
    output logic            sync_pin_o,
    output logic            sync_pin_oe_o,
    // aligned sync event
    output logic            sync_align_o
);
    initial
    begin
        if (STEP_CYC < 1)
            $error("STEP_CYC must be at least one");
    end

    logic [1:0]  role_sync_ff;
    logic [1:0]  pin_sync_ff;
    logic        pin_prev_ff;
    logic        en_prev_ff;
    logic [7:0]  delay_ff;
    logic [7:0]  step_left_ff;
    logic        running_ff;
    logic [15:0] div_ff;
    logic        step_tick;
    logic        fire;

    // two-flop synchronisers on both pins
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            role_sync_ff <= 2'b00;
            pin_sync_ff  <= 2'b00;
            pin_prev_ff  <= 1'b0;
        end
        else
        begin
            role_sync_ff <= {role_sync_ff[0], sync_role_select_pin_i};
            pin_sync_ff  <= {pin_sync_ff[0], sync_pin_i};
            pin_prev_ff  <= pin_sync_ff[1];
        end
    end

    // capture the delay on enable, so software must write it first
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            en_prev_ff <= 1'b0;
            delay_ff   <= SYNC_DELAY_RST;
        end
        else
        begin
            en_prev_ff <= sync_en_i;
            if (sync_en_i && !en_prev_ff)
                delay_ff <= delay_i;
        end
    end

    // 16 us step divider, restarted by each frame reference
    assign step_tick = running_ff && (div_ff == 16'(STEP_CYC - 1));

    always_ff @(posedge clk_i)
    begin
        if (reset_i || frame_ref_i || step_tick)
            div_ff <= 16'h0000;
        else if (running_ff)
            div_ff <= div_ff + 16'h0001;
    end

    // each step of delay shifts the pulse by one divider period
    assign fire = running_ff && (step_left_ff == 8'h00) && (div_ff == 16'h0000);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            running_ff   <= 1'b0;
            step_left_ff <= 8'h00;
        end
        else if (frame_ref_i && sync_en_i)
        begin
            running_ff   <= 1'b1;
            step_left_ff <= delay_ff;
        end
        else if (fire)
            running_ff <= 1'b0;
        else if (step_tick)
            step_left_ff <= step_left_ff - 8'h01;
    end

    // role high drives the shared pin, role low follows it
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync_pin_o    <= 1'b0;
            sync_pin_oe_o <= 1'b0;
            sync_align_o  <= 1'b0;
        end
        else
        begin
            sync_pin_oe_o <= sync_en_i && role_sync_ff[1];
            sync_pin_o    <= fire;
            sync_align_o  <= role_sync_ff[1] ? fire
                                             : (pin_sync_ff[1] && !pin_prev_ff);
        end
    end
endmodule

//--- rtl/lcr_link_regs.sv
// Purpose: link status, mode, power, latency, sync delay and interrupt register bank
// Assumes: core events are one-cycle pulses on clk_i; accesses come decoded from the port
// Notes:   read data is registered, valid one cycle after the read strobe
`timescale 1ns/1ps

module lcr_link_regs
    import lcr_pkg::*;
#(
    parameter int SYNC_STEP = SYNC_STEP_CYC
)
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            reset_i,
    // register access
    input  wire lcr_pkg::lcr_req_t req_i,
    output logic [7:0]           rdata_o,
    output logic                 rvalid_o,
    // radio core status and events
    input  wire lcr_pkg::lcr_core_t core_i,
    input  wire logic            sync_en_i,
    input  wire logic            frame_ref_i,
    // controls to the radio core
    output logic                 reconfig_o,
    output logic                 remote_start_o,
    output logic                 hop_disable_o,
    output logic                 latency_high_o,
    output logic [1:0]           tx_power_o,
    output logic [1:0]           rx_power_o,
    output logic                 mute_o,
    // pins
    input  wire logic            sync_role_select_pin_i,
    input  wire logic            sync_pin_i,
    output logic                 sync_pin_o,
    output logic                 sync_pin_oe_o,
    output logic                 sync_align_o,
    output logic                 irq_o
);
    initial
    begin
        if (SYNC_STEP < 1 || SYNC_STEP > 65535)
            $error("SYNC_STEP out of range");
    end

    logic [7:0] link_mode_ff;
    logic [7:0] mute_hold_ff;
    logic [7:0] latency_ff;
    logic [7:0] tx_power_ff;
    logic [7:0] rx_power_ff;
    logic [7:0] irq_cfg_ff;
    logic [7:0] irq_flags_ff;
    logic [7:0] sync_delay_ff;
    logic [7:0] remote_state_ff;
    logic       link_prev_ff;
    logic       restore;
    logic       wr_flags;
    logic       wr_mode;
    logic       link_broken;
    logic [7:0] nxt_irq_flags;
    logic [7:0] set_flags;
    logic       irq_active;
    logic       mute_int;
    logic       align_int;
    logic       pin_int;
    logic       oe_int;
    logic [7:0] nxt_rdata;

    // a failed link init with the restore bit set returns every register to its reset value
    assign restore = link_mode_ff[MODE_RESTORE_BIT] && core_i.init_fail;

    assign wr_flags = req_i.wr && (req_i.addr == ADDR_IRQ_FLAGS);
    assign wr_mode  = req_i.wr && (req_i.addr == ADDR_LINK_MODE);

    // configuration registers written by software
    always_ff @(posedge clk_i)
    begin
        if (reset_i || restore)
        begin
            link_mode_ff  <= ZERO_RST;
            mute_hold_ff  <= MUTE_HOLD_RST;
            latency_ff    <= LATENCY_RST;
            tx_power_ff   <= POWER_RST;
            rx_power_ff   <= POWER_RST;
            irq_cfg_ff    <= ZERO_RST;
            sync_delay_ff <= SYNC_DELAY_RST;
        end
        else if (req_i.wr)
        begin
            unique case (req_i.addr)
                ADDR_LINK_MODE:  link_mode_ff  <= req_i.wdata & LINK_MODE_MASK;
                ADDR_MUTE_HOLD:  mute_hold_ff  <= req_i.wdata;
                ADDR_LATENCY:    latency_ff    <= req_i.wdata;
                ADDR_TX_POWER:   tx_power_ff   <= req_i.wdata & POWER_MASK;
                ADDR_RX_POWER:   rx_power_ff   <= req_i.wdata & POWER_MASK;
                ADDR_IRQ_CONFIG: irq_cfg_ff    <= req_i.wdata & IRQ_CFG_MASK;
                ADDR_SYNC_DELAY: sync_delay_ff <= req_i.wdata;
                default:         ;
            endcase
        end
    end

    // forced reconfiguration is a pulse; the bit itself never stores
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            reconfig_o <= 1'b0;
        else
            reconfig_o <= wr_mode && req_i.wdata[MODE_RECONF_BIT];
    end

    // remote update state: start from idle or failed, never while busy; core reports the outcome
    always_ff @(posedge clk_i)
    begin
        if (reset_i || restore)
        begin
            remote_state_ff <= REMOTE_IDLE_OK;
            remote_start_o  <= 1'b0;
        end
        else
        begin
            remote_start_o <= 1'b0;
            if (remote_state_ff == REMOTE_BUSY)
            begin
                if (core_i.remote_done)
                    remote_state_ff <= REMOTE_IDLE_OK;
                else if (core_i.remote_fail)
                    remote_state_ff <= REMOTE_FAILED;
            end
            else if (req_i.wr && (req_i.addr == ADDR_REMOTE_UPDATE)
                     && (req_i.wdata == REMOTE_BUSY))
            begin
                remote_state_ff <= REMOTE_BUSY;
                remote_start_o  <= 1'b1;
            end
        end
    end

    // link break is the falling edge of the link status
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            link_prev_ff <= 1'b0;
        else
            link_prev_ff <= core_i.link_up;
    end

    assign link_broken = link_prev_ff && !core_i.link_up;

    // sticky flags: a set in the same cycle as its clear wins
    always_comb
    begin
        set_flags = 8'h00;
        set_flags[IRQ_BROKEN_BIT] = link_broken;
        set_flags[IRQ_REMOTE_BIT] = core_i.remote_done;
        set_flags[IRQ_DATA_BIT]   = core_i.data_rx;
        nxt_irq_flags = irq_flags_ff;
        if (wr_flags)
            nxt_irq_flags = irq_flags_ff & ~req_i.wdata;
        nxt_irq_flags = (nxt_irq_flags | set_flags) & IRQ_FLAG_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || restore)
            irq_flags_ff <= ZERO_RST;
        else
            irq_flags_ff <= nxt_irq_flags;
    end

    // only enabled flags reach the pin; level chosen by config bit 7
    assign irq_active = |(irq_flags_ff & irq_cfg_ff & IRQ_FLAG_MASK);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_o <= 1'b1;
        else
            irq_o <= irq_cfg_ff[IRQ_POL_BIT] ? irq_active : !irq_active;
    end

    // decoded controls, registered so every output starts at a flop
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            hop_disable_o  <= 1'b0;
            latency_high_o <= 1'b1;
            tx_power_o     <= 2'b11;
            rx_power_o     <= 2'b11;
        end
        else
        begin
            hop_disable_o  <= link_mode_ff[MODE_NO_HOP_BIT];
            latency_high_o <= (latency_ff != LATENCY_MEDIUM);
            tx_power_o     <= tx_power_ff[1:0];
            rx_power_o     <= rx_power_ff[1:0];
        end
    end

    // minimum mute interval
    lcr_mute_hold u_mute (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .enable_i     (link_mode_ff[MODE_MUTE_EN_BIT]),
        .hold_count_i (mute_hold_ff),
        .audio_lost_i (core_i.audio_lost),
        .pkt_valid_i  (core_i.pkt_valid),
        .pkt_err_i    (core_i.pkt_err),
        .mute_o       (mute_int)
    );

    // paired receiver sync
    lcr_sync_delay #(
        .STEP_CYC (SYNC_STEP)
    ) u_sync (
        .clk_i                  (clk_i),
        .reset_i                (reset_i),
        .sync_en_i              (sync_en_i),
        .delay_i                (sync_delay_ff),
        .frame_ref_i            (frame_ref_i),
        .sync_role_select_pin_i (sync_role_select_pin_i),
        .sync_pin_i             (sync_pin_i),
        .sync_pin_o             (pin_int),
        .sync_pin_oe_o          (oe_int),
        .sync_align_o           (align_int)
    );

    // submodule outputs are flops already; re-register to keep one cycle of skew uniform
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mute_o        <= 1'b1;
            sync_pin_o    <= 1'b0;
            sync_pin_oe_o <= 1'b0;
            sync_align_o  <= 1'b0;
        end
        else
        begin
            mute_o        <= mute_int;
            sync_pin_o    <= pin_int;
            sync_pin_oe_o <= oe_int;
            sync_align_o  <= align_int;
        end
    end

    // read mux; unmapped addresses and reserved bits read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        unique case (req_i.addr)
            ADDR_IRQ_FLAGS:     nxt_rdata = irq_flags_ff;
            ADDR_LINK_STATE:    nxt_rdata[LINK_UP_BIT] = core_i.link_up;
            ADDR_MUTE_HOLD:     nxt_rdata = mute_hold_ff;
            ADDR_LINK_MODE:     nxt_rdata = link_mode_ff;
            ADDR_REMOTE_UPDATE: nxt_rdata = remote_state_ff;
            ADDR_RX_POWER:      nxt_rdata = rx_power_ff;
            ADDR_LATENCY:       nxt_rdata = latency_ff;
            ADDR_IRQ_CONFIG:    nxt_rdata = irq_cfg_ff;
            ADDR_TX_POWER:      nxt_rdata = tx_power_ff;
            ADDR_SYNC_DELAY:    nxt_rdata = sync_delay_ff;
            default:            nxt_rdata = 8'h00;
        endcase
    end

    // read data lands one cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= req_i.rd;
            if (req_i.rd)
                rdata_o <= nxt_rdata;
        end
    end
endmodule

//--- tb/lcr_link_regs_checker.sv
// Purpose: port checks for the link control and interrupt register bank
// Assumes: only the top ports are seen; the irq shadow mirrors config writes
// Notes:   the shadow ignores restore, so irq checks assume none
`timescale 1ns/1ps
module lcr_link_regs_checker
    import lcr_pkg::*;
#(
    parameter int SYNC_STEP = SYNC_STEP_CYC
)
(
    // clock and reset
    input wire logic              clk_i,
    input wire logic              reset_i,
    // watched inputs
    input wire lcr_pkg::lcr_req_t  req_i,
    input wire lcr_pkg::lcr_core_t core_i,
    // watched outputs
    input wire logic              reconfig_o,
    input wire logic              remote_start_o,
    input wire logic              hop_disable_o,
    input wire logic              latency_high_o,
    input wire logic [1:0]        tx_power_o,
    input wire logic [1:0]        rx_power_o,
    input wire logic              mute_o,
    input wire logic              irq_o
);
    import lcr_pkg::*;
    logic cfg_wr;
    logic quiet;
    logic pol_ff;
    logic brk_en_ff;
    logic [7:0] ev;

    // decoded strobes used by several properties
    assign cfg_wr = req_i.wr && req_i.addr == ADDR_IRQ_CONFIG;
    assign ev = core_i;
    assign quiet = ev[6:0] == 7'h00;

    // shadow of polarity and break enable so the pin level can be predicted
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            pol_ff    <= 1'b0;
            brk_en_ff <= 1'b0;
        end
        else if (cfg_wr)
        begin
            pol_ff    <= req_i.wdata[IRQ_POL_BIT];
            brk_en_ff <= req_i.wdata[IRQ_BROKEN_BIT];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    reconf_pulse_a: assert property (
        reconfig_o == $past(req_i.wr && req_i.addr == ADDR_LINK_MODE && req_i.wdata[4]))
        else $error("reconfig pulse does not match mode write");
    hop_follow_a: assert property (
        req_i.wr && req_i.addr == ADDR_LINK_MODE |-> ##2 hop_disable_o == $past(req_i.wdata[2], 2))
        else $error("hop disable does not follow mode bit");
    tx_power_a: assert property (
        req_i.wr && req_i.addr == ADDR_TX_POWER |-> ##2 tx_power_o == $past(req_i.wdata[1:0], 2))
        else $error("tx power output wrong");
    rx_power_a: assert property (
        req_i.wr && req_i.addr == ADDR_RX_POWER |-> ##2 rx_power_o == $past(req_i.wdata[1:0], 2))
        else $error("rx power output wrong");
    latency_sel_a: assert property (
        req_i.wr && req_i.addr == ADDR_LATENCY |->
        ##2 latency_high_o == ($past(req_i.wdata, 2) != LATENCY_MEDIUM))
        else $error("latency select decode wrong");
    remote_cause_a: assert property (
        remote_start_o |-> $past(req_i.wr && req_i.addr == ADDR_REMOTE_UPDATE && req_i.wdata == 8'h01))
        else $error("remote start without a start write");
    mute_entry_a: assert property (core_i.audio_lost |-> ##2 mute_o)
        else $error("audio loss did not mute");
    break_irq_a: assert property (
        ($fell(core_i.link_up) && brk_en_ff && !cfg_wr && !core_i.init_fail) ##1 !cfg_wr
        |-> ##1 irq_o == pol_ff)
        else $error("link break did not raise irq");
    clear_all_a: assert property (
        (req_i.wr && req_i.addr == ADDR_IRQ_FLAGS && req_i.wdata == 8'h7F && quiet
        && $stable(core_i.link_up)) ##1 !cfg_wr |-> ##1 irq_o == !pol_ff)
        else $error("clear all left irq active");

    // main scenarios reached
    cover property ($rose(irq_o));
    cover property (remote_start_o);
    cover property ($fell(mute_o));
endmodule

bind lcr_link_regs lcr_link_regs_checker #(.SYNC_STEP(SYNC_STEP)) chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .core_i(core_i),
    .reconfig_o(reconfig_o), .remote_start_o(remote_start_o), .hop_disable_o(hop_disable_o),
    .latency_high_o(latency_high_o), .tx_power_o(tx_power_o), .rx_power_o(rx_power_o),
    .mute_o(mute_o), .irq_o(irq_o)
);

//--- tb/lcr_mcu_model.sv
// Purpose: microcontroller side of the register port
// Assumes: one access at a time, strobes held for exactly one sampling edge
// Notes:   a missing read answer returns unknown
`timescale 1ns/1ps
module lcr_mcu_model
    import lcr_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // register port
    output lcr_pkg::lcr_req_t req_o,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        rvalid_i
);
    import lcr_pkg::*;

    // idle port from time zero
    initial req_o = '0;

    // single write, released after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge clk_i);
        req_o <= {2'b10, a, d};
        @(posedge clk_i);
        req_o <= '0;
    end
    endtask

    // single read, data taken in the cycle of the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
        @(posedge clk_i);
        req_o <= {2'b01, a, 8'h00};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
    end
    endtask
endmodule

//--- tb/lcr_link_regs_tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: role pin tied high; shared sync pin idle
// Notes:   fixed-latency waits, guarded by a watchdog
`timescale 1ns/1ps
module lcr_link_regs_tb_top;
    import lcr_pkg::*;
    logic       clk;
    logic       rst;
    lcr_req_t   req;
    lcr_core_t  core;
    logic [7:0] rdata;
    logic       rvalid;
    logic       hop;
    logic       lat_hi;
    logic [1:0] txp;
    logic [1:0] rxp;
    logic       mute;
    logic       irq;
    logic       sen = 1'b0, fref = 1'b0, salign, spin;
    int         errors;
    int         checks_done;
    localparam logic [7:0] RA [10] = '{8'h02, 8'h03, 8'h0B, 8'h36, 8'h49,
                                       8'h52, 8'h53, 8'h56, 8'h57, 8'h3E};
    localparam logic [7:0] RV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
                                       8'h06, 8'h00, 8'h03, 8'h77, 8'h00};

    // short sync step keeps any sync run brief
    lcr_link_regs #(.SYNC_STEP(4)) dut_u (
        .clk_i(clk), .reset_i(rst), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .core_i(core), .sync_en_i(sen), .frame_ref_i(fref), .reconfig_o(),
        .remote_start_o(), .hop_disable_o(hop), .latency_high_o(lat_hi), .tx_power_o(txp),
        .rx_power_o(rxp), .mute_o(mute), .sync_role_select_pin_i(1'b1), .sync_pin_i(1'b0),
        .sync_pin_o(spin), .sync_pin_oe_o(), .sync_align_o(salign), .irq_o(irq)
    );

    lcr_mcu_model mcu_u (.clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

    // free running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
    begin
        mcu_u.rd(a, d);
        chk(d, e);
    end
    endtask

    // one-cycle core event; link_up level is kept
    task automatic pulse(input logic [7:0] m);
    begin
        @(posedge clk);
        core <= core | m;
        @(posedge clk);
        core <= core & 8'h80;
    end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    // main sequence
    initial
    begin
        rst = 1'b1;
        core = '0;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++)
            rchk(RA[i], RV[i]);
        $display("test resets done");
        mcu_u.wr(ADDR_LINK_MODE, 8'hFF);
        rchk(ADDR_LINK_MODE, 8'h45);
        chk(hop, 8'h01);
        mcu_u.wr(ADDR_LINK_MODE, 8'h00);
        idle(2);
        chk(hop, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            mcu_u.wr(ADDR_TX_POWER, 8'(i));
            mcu_u.wr(ADDR_RX_POWER, 8'(3 - i));
            idle(2);
            chk(txp, 8'(i));
            chk(rxp, 8'(3 - i));
        end
        mcu_u.wr(ADDR_LATENCY, LATENCY_MEDIUM);
        idle(2);
        chk(lat_hi, 8'h00);
        mcu_u.wr(ADDR_LATENCY, LATENCY_HIGH);
        idle(2);
        chk(lat_hi, 8'h01);
        mcu_u.wr(ADDR_LINK_STATE, 8'hFF);
        rchk(ADDR_LINK_STATE, 8'h00);
        pulse(8'h80);
        rchk(ADDR_LINK_STATE, 8'h01);
        mcu_u.wr(8'h7F, 8'h5A);
        rchk(8'h7F, 8'h00);
        $display("test controls done");
        mcu_u.wr(ADDR_IRQ_CONFIG, 8'hD8);
        idle(2);
        chk(irq, 8'h00);
        @(posedge clk);
        core <= '0;
        idle(3);
        chk(irq, 8'h01);
        rchk(ADDR_IRQ_FLAGS, 8'h40);
        mcu_u.wr(ADDR_IRQ_FLAGS, 8'h00);
        idle(2);
        chk(irq, 8'h01);
        mcu_u.wr(ADDR_IRQ_FLAGS, 8'h40);
        idle(2);
        chk(irq, 8'h00);
        mcu_u.wr(ADDR_REMOTE_UPDATE, REMOTE_BUSY);
        rchk(ADDR_REMOTE_UPDATE, REMOTE_BUSY);
        pulse(8'h20);
        rchk(ADDR_REMOTE_UPDATE, REMOTE_IDLE_OK);
        pulse(8'h08);
        rchk(ADDR_IRQ_FLAGS, 8'h18);
        chk(irq, 8'h01);
        mcu_u.wr(ADDR_IRQ_FLAGS, 8'h7F);
        idle(2);
        chk(irq, 8'h00);
        rchk(ADDR_IRQ_FLAGS, 8'h00);
        mcu_u.wr(ADDR_IRQ_CONFIG, 8'h08);
        idle(2);
        chk(irq, 8'h01);
        pulse(8'h20);
        pulse(8'h08);
        idle(3);
        chk(irq, 8'h00);
        mcu_u.wr(ADDR_IRQ_FLAGS, 8'h08);
        idle(2);
        chk(irq, 8'h01);
        rchk(ADDR_IRQ_FLAGS, 8'h10);
        mcu_u.wr(ADDR_REMOTE_UPDATE, REMOTE_BUSY);
        pulse(8'h10);
        rchk(ADDR_REMOTE_UPDATE, REMOTE_FAILED);
        mcu_u.wr(ADDR_REMOTE_UPDATE, 8'h05);
        rchk(ADDR_REMOTE_UPDATE, REMOTE_FAILED);
        $display("test interrupts done");
        mcu_u.wr(ADDR_MUTE_HOLD, 8'h01);
        mcu_u.wr(ADDR_LINK_MODE, 8'h01);
        pulse(8'h01);
        repeat (23) pulse(8'h04);
        pulse(8'h06);
        repeat (23) pulse(8'h04);
        idle(3);
        chk(mute, 8'h01);
        pulse(8'h04);
        idle(3);
        chk(mute, 8'h00);
        mcu_u.wr(ADDR_LINK_MODE, 8'h00);
        pulse(8'h01);
        idle(2);
        chk(mute, 8'h01);
        pulse(8'h04);
        idle(3);
        chk(mute, 8'h00);
        $display("test mute done");
        mcu_u.wr(ADDR_SYNC_DELAY, 8'h02);
        sen <= 1'b1;
        idle(2);
        fref <= 1'b1;
        idle(1);
        fref <= 1'b0;
        idle(11);
        chk(salign, 8'h01);
        chk(spin, 8'h01);
        mcu_u.wr(ADDR_LINK_MODE, 8'h40);
        mcu_u.wr(ADDR_TX_POWER, 8'h00);
        pulse(8'h40);
        rchk(ADDR_TX_POWER, 8'h03);
        rchk(ADDR_LINK_MODE, 8'h00);
        $display("test restore and sync done");
        report_and_stop();
    end
endmodule
